// >>> ssc_pkg.sv
package ssc_pkg;
  // Storage shape
  localparam int FIFO_DEPTH = 1024;
  localparam int PTR_W = 10;
  localparam int CNT_W = 11;
  localparam int DLY_TAPS = 16;
  localparam int CLK_PERIOD_NS = 10;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_TXSTOP = 8'h0c;
  localparam logic [7:0] OFS_RXDATA = 8'h10;
  localparam logic [7:0] OFS_DIV = 8'h14;
  localparam logic [7:0] OFS_FRAME = 8'h18;
  localparam logic [7:0] OFS_TIMING = 8'h1c;
  localparam logic [7:0] OFS_WMARK = 8'h20;
  localparam logic [7:0] OFS_LEVEL = 8'h24;
  localparam logic [7:0] OFS_CMD = 8'h28;
  localparam logic [7:0] OFS_TXLEN = 8'h2c;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DIV_RST = 32'h0000_0031;
  localparam logic [31:0] FRAME_RST = 32'h0000_0003;
  localparam logic [31:0] TIMING_RST = 32'h0000_0000;
  localparam logic [31:0] WMARK_RST = 32'h0200_0200;
  localparam logic [4:0] TXLEN_RST = 5'h1f;
  // Status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_TX_FULL = 2;
  localparam int ST_RX_EMPTY = 3;
  localparam int ST_RX_FULL = 4;
  localparam int ST_TX_WM = 5;
  localparam int ST_RX_WM = 6;
  localparam int ST_TX_FULL_EVT = 8;
  localparam int ST_RX_FULL_EVT = 9;
  localparam int LVL_RX_POS = 16;

  typedef enum logic [1:0] {TRIG_SINGLE, TRIG_DRAIN, TRIG_GATED, TRIG_STOP} ssc_trig_t;
  typedef enum logic [1:0] {FM_BIT, FM_NBITS, FM_WORD, FM_FRAME} ssc_fm_t;
  typedef struct packed {
    logic [13:0] rsvd;
    logic [4:0] wlen_m1;
    ssc_fm_t fm_len;
    logic ack_en;
    logic dyn_len;
    logic invert;
    logic nrzi;
    logic level_sens;
    logic trig_line;
    ssc_trig_t trig_mode;
    logic clk_ext;
    logic rx_dir;
    logic enable;
  } ssc_ctrl_t;
  typedef struct packed {
    logic [10:0] rsvd;
    logic [4:0] fm_bits_m1;
    logic [5:0] rsvd2;
    logic [9:0] bytes_m1;
  } ssc_frame_t;
  typedef struct packed {
    logic [23:0] rsvd;
    logic [3:0] data_dly;
    logic [3:0] fm_phase;
  } ssc_timing_t;
  typedef struct packed {
    logic stop;
    logic [4:0] wlen_m1;
    logic [31:0] data;
  } ssc_txent_t;
endpackage

// >>> ssc_channel.sv
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
module ssc_fifo #(
  parameter int W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic full,
  output logic empty,
  output logic [ssc_pkg::CNT_W-1:0] count
);
  import ssc_pkg::*;
  logic [W-1:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] cnt_r;
  logic do_push;
  logic do_pop;

  // Refused pushes and pops are simply dropped
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign full = (cnt_r == CNT_W'(FIFO_DEPTH));
  assign empty = (cnt_r == '0);
  assign count = cnt_r;
  assign rdata = mem[rd_ptr_r];

  // Data storage needs no reset
  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= wdata;
    end
  end

  // Pointers and fill level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) wr_ptr_r <= wr_ptr_r + PTR_W'(1);
      if (do_pop) rd_ptr_r <= rd_ptr_r + PTR_W'(1);
      cnt_r <= cnt_r + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end
endmodule // ssc_fifo

// Functional notes
// - Serial mode enabled per channel; other channels' counters untouched.
// - Word length programmable from three to thirty-two bits, both directions.
// - Exactly one bit shifted per serial clock period, internal or external.
// - Separate 1024x32 transmit and receive FIFOs, each with a watermark.
// - Event raised when a FIFO becomes full.
// - Transmit FIFO mode with per-word variable length.
// - Transmit clock from external input or internal prescaled clock.
// - Start by software or qualifier line, edge or level selectable.
// - Single mode sends one frame per trigger then waits.
// - Drain mode keeps sending until transmit FIFO is empty.
// - Gated mode sends while trigger held, never cutting a word.
// - Stop mode ends after word with stop marker; 32-bit words kept.
// - In transmit, strobe output carries frame marker on external clock, else bit clock.
// - Receive drives baud clock out and samples data on clock input.
// - Frame marker lasts one bit, N bits, one word or one frame.
// - Frame marker phase shifted in steps of one internal clock.
// - Frame length from one to 1024 bytes.
// - Optional NRZ or NRZI coding on transmit and receive.
// - Optional line inversion before decode and after encode.
// - Data edge delayed in steps of one internal clock.
// - Acknowledge taken from next-higher channel, pairing two channels.
module ssc_channel (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic serial_clock_input,
  input wire logic start_condition_input,
  input wire logic frame_marker_input,
  input wire logic ack_input,
  output logic serial_clock_output,
  output logic strobe_output_line,
  output logic frame_marker_output,
  output logic mode_active,
  output logic fifo_full_event
);
  import ssc_pkg::*;
  typedef enum {TX_IDLE, TX_RUN} ssc_txst_t;

  ssc_ctrl_t ctrl_r;
  ssc_frame_t frame_r;
  ssc_timing_t timing_r;
  logic [31:0] div_r, wmark_r, hrdata_r, rd_mux;
  logic [4:0] txlen_r;
  logic [7:0] wr_addr_r;
  logic wr_pend_r, start_cmd_r, tx_fevt_r, rx_fevt_r, full_evt_r;
  logic [3:0] sync1_r, sync2_r, sync3_r;
  logic [31:0] pre_cnt_r;
  logic bclk_r, tick, tick_int;
  logic [DLY_TAPS-2:0] tick_dl_r;
  ssc_txst_t tx_state_r;
  logic [31:0] tx_sh_r, rx_sh_r;
  logic [5:0] tx_left_r, rx_left_r, cur_len;
  logic [13:0] frame_left_r, fm_left_r, rx_frame_left_r, fbits, fm_dur;
  logic stop_seen_r, pend_bit_r, nrz_state_r, fm_pend_r, fm_out_r, rx_prev_r;
  logic bus_act, rd_pop, tx_push, tx_pop, rx_push, trig_evt, trig_lvl, word_end;
  logic end_now, ack_hold, tx_load, rx_bit, rx_din;
  ssc_txent_t tx_went, tx_rent, tx_ent_aligned;
  logic [31:0] aligned;
  logic tx_full, tx_empty, rx_full, rx_empty, tx_full_d_r, rx_full_d_r;
  logic [CNT_W-1:0] tx_count, rx_count;
  logic [31:0] rx_rdata;

  // short lengths clamp
  // Length decode shared by control and per-word fields
  function automatic logic [5:0] eff_len(input logic [4:0] m1);
    eff_len = (m1 < 5'd2) ? 6'd3 : {1'b0, m1} + 6'd1;
  endfunction

  // Delayed tick tap, zero means no delay
  function automatic logic tap(input logic [3:0] k, input logic t,
                               input logic [DLY_TAPS-2:0] dl);
    tap = (k == 4'h0) ? t : dl[k - 4'h1];
  endfunction

  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign bus_act = hsel && htrans[1] && hready;
  assign rd_pop = bus_act && !hwrite && (haddr[7:0] == OFS_RXDATA) && ctrl_r.enable;
  assign mode_active = ctrl_r.enable;
  assign fifo_full_event = full_evt_r;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: rd_mux = ctrl_r;
      OFS_STAT: begin
        rd_mux[ST_BUSY] = (tx_state_r == TX_RUN);
        rd_mux[ST_TX_EMPTY] = tx_empty;
        rd_mux[ST_TX_FULL] = tx_full;
        rd_mux[ST_RX_EMPTY] = rx_empty;
        rd_mux[ST_RX_FULL] = rx_full;
        rd_mux[ST_TX_WM] = (tx_count <= wmark_r[CNT_W-1:0]);
        rd_mux[ST_RX_WM] = (rx_count >= wmark_r[LVL_RX_POS +: CNT_W]);
        rd_mux[ST_TX_FULL_EVT] = tx_fevt_r;
        rd_mux[ST_RX_FULL_EVT] = rx_fevt_r;
      end
      OFS_RXDATA: rd_mux = rx_rdata;
      OFS_DIV: rd_mux = div_r;
      OFS_FRAME: rd_mux = frame_r;
      OFS_TIMING: rd_mux = timing_r;
      OFS_WMARK: rd_mux = wmark_r;
      OFS_LEVEL: begin
        rd_mux[CNT_W-1:0] = tx_count;
        rd_mux[LVL_RX_POS +: CNT_W] = rx_count;
      end
      OFS_TXLEN: rd_mux = {27'h0, txlen_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Address phase capture, read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= bus_act && hwrite;
      if (bus_act) wr_addr_r <= haddr[7:0];
      if (bus_act && !hwrite) hrdata_r <= rd_mux;
    end
  end

  // Writable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RST;
      div_r <= DIV_RST;
      frame_r <= FRAME_RST;
      timing_r <= TIMING_RST;
      wmark_r <= WMARK_RST;
      txlen_r <= TXLEN_RST;
      start_cmd_r <= 1'b0;
    end else begin
      start_cmd_r <= wr_pend_r && (wr_addr_r == OFS_CMD) && hwdata[0];
      if (wr_pend_r) begin
        case (wr_addr_r)
          OFS_CTRL: ctrl_r <= hwdata;
          OFS_DIV: div_r <= hwdata;
          OFS_FRAME: frame_r <= hwdata;
          OFS_TIMING: timing_r <= hwdata;
          OFS_WMARK: wmark_r <= hwdata;
          OFS_TXLEN: txlen_r <= hwdata[4:0];
          default: ;
        endcase
      end
    end
  end

  // full events, set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_full_d_r <= 1'b0;
      rx_full_d_r <= 1'b0;
      tx_fevt_r <= 1'b0;
      rx_fevt_r <= 1'b0;
      full_evt_r <= 1'b0;
    end else begin
      tx_full_d_r <= tx_full;
      rx_full_d_r <= rx_full;
      full_evt_r <= (tx_full && !tx_full_d_r) || (rx_full && !rx_full_d_r);
      if (tx_full && !tx_full_d_r) tx_fevt_r <= 1'b1;
      else if (wr_pend_r && wr_addr_r == OFS_STAT && hwdata[ST_TX_FULL_EVT]) tx_fevt_r <= 1'b0;
      if (rx_full && !rx_full_d_r) rx_fevt_r <= 1'b1;
      else if (wr_pend_r && wr_addr_r == OFS_STAT && hwdata[ST_RX_FULL_EVT]) rx_fevt_r <= 1'b0;
    end
  end

  // transmit FIFO, stop marker and length ride beside the data
  assign tx_push = wr_pend_r && (wr_addr_r == OFS_TXDATA || wr_addr_r == OFS_TXSTOP);
  assign tx_went = '{stop: (wr_addr_r == OFS_TXSTOP), wlen_m1: txlen_r, data: hwdata};
  ssc_fifo #(.W($bits(ssc_txent_t))) u_txfifo (
    .hclk(hclk), .hresetn(hresetn), .push(tx_push), .wdata(tx_went), .pop(tx_pop),
    .rdata(tx_rent), .full(tx_full), .empty(tx_empty), .count(tx_count)
  );
  // receive FIFO; words arriving while full are lost
  ssc_fifo #(.W(32)) u_rxfifo (
    .hclk(hclk), .hresetn(hresetn), .push(rx_push), .wdata({rx_sh_r[30:0], rx_bit}),
    .pop(rd_pop), .rdata(rx_rdata), .full(rx_full), .empty(rx_empty), .count(rx_count)
  );

  // two-flop synchronisers, third stage only for edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else begin
      sync1_r <= {ack_input, frame_marker_input, start_condition_input, serial_clock_input};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // internal bit clock from the prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= 32'h0000_0000;
      bclk_r <= 1'b0;
    end else if (!ctrl_r.enable || pre_cnt_r >= div_r) begin
      pre_cnt_r <= 32'h0000_0000;
      bclk_r <= ctrl_r.enable && !bclk_r;
    end else begin
      pre_cnt_r <= pre_cnt_r + 32'h0000_0001;
    end
  end
  assign tick_int = ctrl_r.enable && (pre_cnt_r >= div_r);

  // one tick per serial period; receive samples on the falling half
  always_comb begin
    if (ctrl_r.rx_dir) tick = tick_int && bclk_r;
    else if (ctrl_r.clk_ext) tick = ctrl_r.enable && sync2_r[0] && !sync3_r[0];
    else tick = tick_int && !bclk_r;
  end

  // tick delay line for marker phase and data edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_dl_r <= '0;
    else tick_dl_r <= {tick_dl_r[DLY_TAPS-3:0], tick};
  end

  assign trig_lvl = sync2_r[1];
  assign trig_evt = ctrl_r.trig_line ? (ctrl_r.level_sens ? trig_lvl : trig_lvl && !sync3_r[1])
                                     : start_cmd_r;
  assign fbits = {({1'b0, frame_r.bytes_m1} + 11'd1), 3'b000};
  assign cur_len = ctrl_r.dyn_len ? eff_len(tx_rent.wlen_m1) : eff_len(ctrl_r.wlen_m1);
  assign aligned = tx_rent.data << (6'd32 - cur_len);
  assign tx_ent_aligned = '{stop: tx_rent.stop, wlen_m1: tx_rent.wlen_m1, data: aligned};

  always_comb begin
    case (ctrl_r.fm_len)
      FM_BIT: fm_dur = 14'd1;
      FM_NBITS: fm_dur = {9'd0, frame_r.fm_bits_m1} + 14'd1;
      FM_WORD: fm_dur = {8'd0, cur_len};
      default: fm_dur = fbits;
    endcase
  end

  // Word boundary decisions; stop only between words
  assign word_end = (tx_state_r == TX_RUN) && tick && (tx_left_r == 6'd0);
  always_comb begin
    end_now = tx_empty;
    case (ctrl_r.trig_mode)
      TRIG_SINGLE: end_now = tx_empty || (frame_left_r == 14'd0 && !stop_seen_r);
      TRIG_DRAIN: end_now = tx_empty;
      TRIG_GATED: end_now = tx_empty || !trig_lvl;
      TRIG_STOP: end_now = tx_empty || stop_seen_r;
      default: end_now = 1'b1;
    endcase
  end
  // acknowledge from the neighbouring channel holds the next word
  assign ack_hold = ctrl_r.ack_en && !sync2_r[3];
  assign tx_load = word_end && !end_now && !ack_hold;
  assign tx_pop = tx_load;

  // Transmit state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_r <= TX_IDLE;
      stop_seen_r <= 1'b0;
    end else if (!ctrl_r.enable || ctrl_r.rx_dir) begin
      tx_state_r <= TX_IDLE;
    end else begin
      case (tx_state_r)
        TX_IDLE: begin
          // Single mode fakes a finished previous frame as a marker
          stop_seen_r <= (ctrl_r.trig_mode == TRIG_SINGLE);
          if (trig_evt) tx_state_r <= TX_RUN;
        end
        TX_RUN: begin
          if (word_end && end_now) tx_state_r <= TX_IDLE;
          if (tx_load) stop_seen_r <= (ctrl_r.trig_mode == TRIG_STOP) && tx_rent.stop;
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh_r <= 32'h0000_0000;
      tx_left_r <= 6'd0;
      frame_left_r <= 14'd0;
      fm_left_r <= 14'd0;
      pend_bit_r <= 1'b0;
      fm_pend_r <= 1'b0;
    end else if (tx_state_r == TX_IDLE) begin
      tx_left_r <= 6'd0;
      frame_left_r <= 14'd0;
      fm_pend_r <= 1'b0;
    end else if (tx_load) begin
      pend_bit_r <= tx_ent_aligned.data[31];
      tx_sh_r <= {tx_ent_aligned.data[30:0], 1'b0};
      tx_left_r <= cur_len - 6'd1;
      fm_pend_r <= (frame_left_r == 14'd0) || (fm_left_r != 14'd0);
      frame_left_r <= (frame_left_r == 14'd0) ? fbits - 14'd1 : frame_left_r - 14'd1;
      if (frame_left_r == 14'd0) fm_left_r <= fm_dur - 14'd1;
      else if (fm_left_r != 14'd0) fm_left_r <= fm_left_r - 14'd1;
    end else if (tick && tx_left_r != 6'd0) begin
      pend_bit_r <= tx_sh_r[31];
      tx_sh_r <= {tx_sh_r[30:0], 1'b0};
      tx_left_r <= tx_left_r - 6'd1;
      fm_pend_r <= (fm_left_r != 14'd0);
      if (fm_left_r != 14'd0) fm_left_r <= fm_left_r - 14'd1;
      if (frame_left_r != 14'd0) frame_left_r <= frame_left_r - 14'd1;
    end
  end

  // encode at the delayed data edge; delay tap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nrz_state_r <= 1'b0;
      fm_out_r <= 1'b0;
    end else begin
      if (tap(timing_r.data_dly, tick, tick_dl_r) && tx_state_r == TX_RUN)
        nrz_state_r <= ctrl_r.nrzi ? nrz_state_r ^ pend_bit_r : pend_bit_r;
      // marker moves at its own phase tap
      if (tap(timing_r.fm_phase, tick, tick_dl_r))
        fm_out_r <= fm_pend_r && (tx_state_r == TX_RUN);
    end
  end

  // receive drives baud clock; inversion after encoding
  assign serial_clock_output = !ctrl_r.enable ? 1'b0 :
                               ctrl_r.rx_dir ? bclk_r : nrz_state_r ^ ctrl_r.invert;
  assign strobe_output_line = (!ctrl_r.enable || ctrl_r.rx_dir) ? 1'b0 :
                              ctrl_r.clk_ext ? fm_out_r : bclk_r;
  assign frame_marker_output = fm_out_r;

  assign rx_din = sync2_r[0] ^ ctrl_r.invert;
  assign rx_bit = ctrl_r.nrzi ? rx_din ^ rx_prev_r : rx_din;
  assign rx_push = tick && ctrl_r.rx_dir && (rx_left_r == 6'd1);

  // frame from the remote marker starts reception
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_sh_r <= 32'h0000_0000;
      rx_left_r <= 6'd0;
      rx_frame_left_r <= 14'd0;
      rx_prev_r <= 1'b0;
    end else if (!ctrl_r.enable || !ctrl_r.rx_dir) begin
      rx_left_r <= 6'd0;
      rx_frame_left_r <= 14'd0;
    end else if (tick) begin
      rx_prev_r <= rx_din;
      rx_sh_r <= {rx_sh_r[30:0], rx_bit};
      if (rx_left_r != 6'd0) begin
        rx_left_r <= rx_left_r - 6'd1;
        if (rx_frame_left_r != 14'd0) rx_frame_left_r <= rx_frame_left_r - 14'd1;
      end else if (rx_frame_left_r != 14'd0 || sync2_r[2]) begin
        // Fresh word starts clean, so short words read back zero-extended
        rx_sh_r <= {31'h0000_0000, rx_bit};
        rx_left_r <= eff_len(ctrl_r.wlen_m1) - 6'd1;
        rx_frame_left_r <= (rx_frame_left_r == 14'd0) ? fbits - 14'd1 : rx_frame_left_r - 14'd1;
      end
    end
  end

  sequence s_last_bit;
    tx_state_r == TX_RUN && tick && tx_left_r == 6'd1;
  endsequence
  property p_len_range;
    @(posedge hclk) disable iff (!hresetn) cur_len >= 6'd3 && cur_len <= 6'd32;
  endproperty
  a_len_range: assert property (p_len_range) else $error("word length out of range");
  property p_shift_on_tick;
    @(posedge hclk) disable iff (!hresetn)
      (tx_state_r == TX_RUN && !tick) |=> $stable(tx_sh_r) && $stable(tx_left_r);
  endproperty
  a_shift_on_tick: assert property (p_shift_on_tick) else $error("shift without tick");
  property p_full_level;
    @(posedge hclk) disable iff (!hresetn)
      (tx_full && !tx_pop) |=> tx_count == CNT_W'(FIFO_DEPTH);
  endproperty
  a_full_level: assert property (p_full_level) else $error("tx full flag wrong");
  property p_full_event;
    @(posedge hclk) disable iff (!hresetn) $rose(tx_full) |=> fifo_full_event && tx_fevt_r;
  endproperty
  a_full_event: assert property (p_full_event) else $error("full event missing");
  property p_disabled_idle;
    @(posedge hclk) disable iff (!hresetn) !ctrl_r.enable |=> tx_state_r == TX_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled channel busy");
  property p_drain_stop;
    @(posedge hclk) disable iff (!hresetn) (word_end && tx_empty) |=> tx_state_r == TX_IDLE;
  endproperty
  a_drain_stop: assert property (p_drain_stop) else $error("ran on empty fifo");
  property p_whole_word;
    @(posedge hclk) disable iff (!hresetn)
      ((ctrl_r.enable && !ctrl_r.rx_dir) and s_last_bit) |=> tx_state_r == TX_RUN;
  endproperty
  a_whole_word: assert property (p_whole_word) else $error("word cut short");
  property p_single_end;
    @(posedge hclk) disable iff (!hresetn)
      (word_end && ctrl_r.trig_mode == TRIG_SINGLE && frame_left_r == 14'd0 && !stop_seen_r)
      |=> tx_state_r == TX_IDLE;
  endproperty
  a_single_end: assert property (p_single_end) else $error("single frame overran");
  property p_strobe_sel;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl_r.enable && !ctrl_r.rx_dir) |-> strobe_output_line == (ctrl_r.clk_ext ? fm_out_r : bclk_r);
  endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe source wrong");
endmodule // ssc_channel

// >>> ssc_remote.sv
`timescale 1ns/1ns
module ssc_remote (
  input wire logic data_line,
  input wire logic bit_clk,
  input wire logic frame_line,
  input wire logic baud_clk,
  input wire logic clr,
  input wire logic [7:0] send_word,
  input wire logic send_go,
  output logic data_in_line,
  output logic marker_line,
  output logic [7:0] got_word,
  output logic [5:0] got_cnt
);
  logic [7:0] sh;
  int left = 0;
  // Lines start low; the marker stays quiet until the first frame
  initial begin
    data_in_line = 1'b0;
    marker_line = 1'b0;
  end
  // Sample mid-period from the marker on; the bit clock runs free between frames
  always @(negedge bit_clk or posedge clr) begin
    if (clr) begin
      got_cnt <= '0;
      got_word <= '0;
    end else if (frame_line || (got_cnt != 6'h00 && got_cnt < 6'h08)) begin
      got_word <= {got_word[6:0], data_line};
      got_cnt <= got_cnt + 6'h01;
    end
  end
  // Send MSB first on the device baud clock
  // marker with data
  always @(posedge baud_clk or posedge send_go) begin
    if (send_go) begin
      sh <= send_word;
      left <= 8;
    end else if (left > 0) begin
      data_in_line <= sh[7];
      sh <= {sh[6:0], 1'b0};
      marker_line <= (left == 8);
      left <= left - 1;
    end else begin
      data_in_line <= ~data_in_line; // Idle line toggles on each rising baud clock edge and holds between them
      marker_line <= 1'b0;
    end
  end
endmodule // ssc_remote

// >>> ssc_channel_tb_top.sv
`timescale 1ns/1ns
module ssc_channel_tb_top;
  import ssc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic start_in = 1'b0;
  logic clr = 1'b0;
  logic go = 1'b0;
  int evt_count = 0;
  logic [7:0] send_word = '0;
  logic [31:0] hrdata, q;
  logic hreadyout, sclk_in, fm_in, sclk_out, strobe, active, full_evt, fm_out, resp;
  logic [7:0] got_word;
  logic [5:0] got_cnt;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // 100 MHz clock
  always #5 hclk = ~hclk;

  ssc_channel u_ssc_channel (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(resp), .serial_clock_input(sclk_in),
    .start_condition_input(start_in), .frame_marker_input(fm_in), .ack_input(1'b1),
    .serial_clock_output(sclk_out), .strobe_output_line(strobe), .frame_marker_output(fm_out),
    .mode_active(active), .fifo_full_event(full_evt));

  ssc_remote u_ssc_remote (.data_line(sclk_out), .bit_clk(strobe), .baud_clk(sclk_out),
    .clr(clr), .send_word(send_word), .send_go(go), .frame_line(fm_out),
    .data_in_line(sclk_in),
    .marker_line(fm_in), .got_word(got_word), .got_cnt(got_cnt));

  // Cycle count for the timeout; count the one-cycle full pulses
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (full_evt === 1'b1) evt_count <= evt_count + 1;
  end

  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One AHB single transfer; read data lands in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task rchk(input string n, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(n, exp, q);
    chk("hresp", 32'h0, {31'h0, resp});
  endtask

  task reset_case;
    rchk("ctrl", OFS_CTRL, CTRL_RST);
    rchk("div", OFS_DIV, DIV_RST);
    rchk("frame", OFS_FRAME, FRAME_RST);
    rchk("timing", OFS_TIMING, TIMING_RST);
    rchk("wmark", OFS_WMARK, WMARK_RST);
    rchk("txlen", OFS_TXLEN, {27'h0, TXLEN_RST});
    rchk("stat", OFS_STAT, 32'h0000_002a);
    rchk("unmapped", 8'h30, 32'h0);
    $display("done reset");
  endtask

  // One byte frame, 8-bit words, bit clock period 8 cycles
  task tx_case(input string n, input logic [31:0] ctrl, input logic [7:0] w, exp,
               input logic by_line);
    int k;
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_DIV, 32'h3);
    bus(1'b1, OFS_FRAME, 32'h0);
    bus(1'b1, OFS_TXDATA, {24'h0, w});
    clr <= 1'b1;
    bus(1'b1, OFS_CTRL, ctrl);
    clr <= 1'b0;
    @(posedge hclk);
    chk("mode_active", 32'h1, {31'h0, active});
    if (by_line) start_in <= 1'b1;
    else bus(1'b1, OFS_CMD, 32'h1);
    k = 0;
    while (got_cnt !== 6'd8 && k < 2000) begin
      @(posedge hclk);
      k++;
    end
    repeat (60) @(posedge hclk);
    chk(n, {24'h0, exp}, {24'h0, got_word});
    chk("bit count", 32'h8, {26'h0, got_cnt});
    start_in <= 1'b0;
    $display("done %s", n);
  endtask

  task rx_case;
    int k;
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_DIV, 32'h7);
    bus(1'b1, OFS_CTRL, 32'h0000_e003);
    send_word <= 8'h3c;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    k = 0;
    do begin
      bus(1'b0, OFS_STAT, 32'h0);
      k++;
    end while (q[ST_RX_EMPTY] !== 1'b0 && k < 300);
    rchk("rx level", OFS_LEVEL, 32'h0001_0000);
    rchk("rx word", OFS_RXDATA, 32'h0000_003c);
    $display("done rx");
  endtask

  task full_case;
    int e0;
    bus(1'b1, OFS_CTRL, 32'h0);
    e0 = evt_count;
    for (int i = 0; i < FIFO_DEPTH; i++) bus(1'b1, OFS_TXDATA, i);
    bus(1'b1, OFS_TXDATA, 32'hdead_beef);
    @(posedge hclk);
    chk("full event", 32'h1, evt_count - e0);
    rchk("tx level", OFS_LEVEL, 32'h0000_0400);
    rchk("stat full", OFS_STAT, 32'h0000_010c);
    bus(1'b1, OFS_STAT, 32'h0000_0100);
    rchk("stat clear", OFS_STAT, 32'h0000_000c);
    $display("done full");
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    fork
      begin
        reset_case();
        tx_case("tx plain", 32'h0000_e001, 8'ha5, 8'ha5, 1'b0);
        tx_case("tx invert", 32'h0000_e101, 8'ha5, 8'h5a, 1'b0);
        tx_case("tx line", 32'h0000_e021, 8'h96, 8'h96, 1'b1);
        tx_case("tx drain", 32'h0000_e009, 8'h81, 8'h81, 1'b0);
        rx_case();
        full_case();
      end
      wait (cycles >= 30000);
    join_any
    // Hitting the ceiling counts as a mismatch
    if (cycles >= 30000) bad_count++;
    test_done();
  end
endmodule // ssc_channel_tb_top
